// ===== rtl/dfc_consts.vh
`ifndef DFC_CONSTS_VH
`define DFC_CONSTS_VH

// ==================================================
// register indices (byte address is four times these)
`define DFC_IDX_CHAN_SEL     6'h00
`define DFC_IDX_GLOBAL       6'h02
`define DFC_IDX_CHANNEL      6'h03
`define DFC_IDX_FTW          6'h04
`define DFC_IDX_SWEEP_RATE   6'h07
`define DFC_IDX_DELTA        6'h08
`define DFC_IDX_UPDATE       6'h09

// ==================================================
// decode codes
`define DFC_DEC_NONE         3'h0
`define DFC_DEC_CHAN_SEL     3'h1
`define DFC_DEC_GLOBAL       3'h2
`define DFC_DEC_CHANNEL      3'h3
`define DFC_DEC_FTW          3'h4
`define DFC_DEC_SWEEP_RATE   3'h5
`define DFC_DEC_DELTA        3'h6
`define DFC_DEC_UPDATE       3'h7

// ==================================================
// global function control fields
`define DFC_G_AUTO_SWEEP     15
`define DFC_G_CLR_SWEEP      14
`define DFC_G_AUTO_PHASE     13
`define DFC_G_CLR_PHASE      12
`define DFC_G_MASK           16'hf0f3
`define DFC_G_RESET          16'h0000

// ==================================================
// channel function control fields
`define DFC_C_MOD_HI         23
`define DFC_C_MOD_LO         22
`define DFC_C_NO_DWELL       15
`define DFC_C_SWEEP_EN       14
`define DFC_C_SRR_UPD        13
`define DFC_C_FSC_HI         9
`define DFC_C_FSC_LO         8
`define DFC_C_DIG_PD         7
`define DFC_C_DAC_PD         6
`define DFC_C_MASK           24'hc0e3ff
`define DFC_C_RESET          24'h000300

// ==================================================
// own registers
`define DFC_SEL_RESET        2'h3
`define DFC_RATE_RESET       8'h01
`define DFC_RESP_OKAY        2'h0
`define DFC_RESP_SLVERR      2'h2

`endif

// ===== rtl/dfc_sync3.v
`timescale 1ns/10ps

// ==================================================
// three-stage pin synchroniser with agreement filter
module dfc_sync3 (
	input  wire mclk,
	input  wire srst,
	input  wire pin_in,
	output reg  level_reg,
	output reg  rise_reg
);

	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	always @(posedge mclk) begin
		if (srst) begin
			s1_reg    <= 1'b0;
			s2_reg    <= 1'b0;
			s3_reg    <= 1'b0;
			level_reg <= 1'b0;
			rise_reg  <= 1'b0;
		end else begin
			s1_reg   <= pin_in;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			rise_reg <= 1'b0;
			// a change counts only once stages two and three agree
			if (s2_reg == s3_reg) begin
				level_reg <= s2_reg;
				rise_reg  <= s2_reg & ~level_reg;
			end
		end
	end

endmodule

// ===== rtl/dfc_chan_core.v
`timescale 1ns/10ps

// ==================================================
// one channel: ramp-rate timer, sweep and phase accumulators
module dfc_chan_core #(
	parameter AW = 32,
	parameter RW = 8
) (
	input  wire          mclk,
	input  wire          srst,
	input  wire [AW-1:0] ftw,
	input  wire [AW-1:0] delta,
	input  wire [RW-1:0] rate,
	input  wire          sweep_en,
	input  wire          no_dwell,
	input  wire          srr_upd,
	input  wire          dig_pd,
	input  wire          upd,
	input  wire          auto_sweep,
	input  wire          clr_sweep,
	input  wire          auto_phase,
	input  wire          clr_phase,
	output reg  [AW-1:0] phase_reg,
	output reg  [AW-1:0] sweep_reg,
	output reg           at_end_reg
);

	reg  [RW-1:0] timer_reg;
	wire          tick;
	wire [AW:0]   sweep_sum;
	wire [AW-1:0] freq;

	assign tick      = (timer_reg <= {{(RW-1){1'b0}}, 1'b1});
	assign sweep_sum = {1'b0, sweep_reg} + {1'b0, delta};
	assign freq      = sweep_en ? ftw + sweep_reg : ftw;

	always @(posedge mclk) begin
		if (srst) begin
			timer_reg <= {RW{1'b0}};
		end else if (upd && srr_upd) begin
			timer_reg <= rate;
		end else if (tick) begin
			timer_reg <= rate;
		end else begin
			timer_reg <= timer_reg - {{(RW-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge mclk) begin
		if (srst || clr_sweep) begin
			sweep_reg  <= {AW{1'b0}};
			at_end_reg <= 1'b0;
		end else if (upd && auto_sweep) begin
			sweep_reg  <= {AW{1'b0}};
			at_end_reg <= 1'b0;
		end else if (sweep_en && tick && !dig_pd) begin
			if (!sweep_sum[AW]) begin
				sweep_reg <= sweep_sum[AW-1:0];
			end else if (sweep_en && no_dwell) begin
				sweep_reg  <= {AW{1'b0}};
				at_end_reg <= 1'b0;
			end else begin
				// dwell at the top of the ramp
				sweep_reg  <= {AW{1'b1}};
				at_end_reg <= 1'b1;
			end
		end
	end
	// otherwise a new delta is used from the next tick, with no update needed

	always @(posedge mclk) begin
		if (srst || clr_phase) begin
			phase_reg <= {AW{1'b0}};
		end else if (upd && auto_phase) begin
			phase_reg <= {AW{1'b0}};
		end else if (!dig_pd) begin
			phase_reg <= phase_reg + freq;
		end
	end

endmodule

// ===== rtl/dfc_top.v
// Notes on behaviour
// - autoclear sweep off: delta applies at once, not held for update
// - autoclear sweep on: update zeroes sweep accumulators
// - sweep clear bit holds sweep accumulators cleared
// - autoclear phase off: tuning word applies at once, not held for update
// - autoclear phase on: update zeroes phase accumulators
// - phase clear bit holds phase accumulators cleared
// - two-bit field selects channel modulation type
// - no-dwell active only while sweep enabled
// - sweep adds delta at ramp rate
// - reload bit clear: timer reloads at one
// - reload bit set: also reload on update
// - full-scale current field resets to three
// - digital power-down bit freezes channel accumulators, timer keeps running
// - DAC power-down clear keeps DAC enabled
// - DAC power-down set disables channel DAC
`timescale 1ns/10ps
`include "dfc_consts.vh"

module dfc_top #(
	parameter AW = 32,
	parameter RW = 8
) (
	input  wire          mclk,
	input  wire          srst,
	input  wire          io_update_pin,
	input  wire [31:0]   s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [31:0]   s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	output wire [AW-1:0] phase_acc0,
	output wire [AW-1:0] phase_acc1,
	output wire [AW-1:0] sweep_acc0,
	output wire [AW-1:0] sweep_acc1,
	output wire [3:0]    modulation_type_select,
	output wire [3:0]    dac_fsc,
	output wire [1:0]    dig_powerdown,
	output wire [1:0]    dac_powerdown
);

	// ==================================================
	// helpers
	function [2:0] dec_addr;
		input [31:0] addr;
		begin
			if (addr[31:8] != 24'h000000 || addr[1:0] != 2'h0) begin
				dec_addr = `DFC_DEC_NONE;
			end else if (addr[7:2] == `DFC_IDX_CHAN_SEL) begin
				dec_addr = `DFC_DEC_CHAN_SEL;
			end else if (addr[7:2] == `DFC_IDX_GLOBAL) begin
				dec_addr = `DFC_DEC_GLOBAL;
			end else if (addr[7:2] == `DFC_IDX_CHANNEL) begin
				dec_addr = `DFC_DEC_CHANNEL;
			end else if (addr[7:2] == `DFC_IDX_FTW) begin
				dec_addr = `DFC_DEC_FTW;
			end else if (addr[7:2] == `DFC_IDX_SWEEP_RATE) begin
				dec_addr = `DFC_DEC_SWEEP_RATE;
			end else if (addr[7:2] == `DFC_IDX_DELTA) begin
				dec_addr = `DFC_DEC_DELTA;
			end else if (addr[7:2] == `DFC_IDX_UPDATE) begin
				dec_addr = `DFC_DEC_UPDATE;
			end else begin
				dec_addr = `DFC_DEC_NONE;
			end
		end
	endfunction

	// byte-lane merge, bits outside mask stay zero
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		input [31:0] mask;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = data[i*8 +: 8];
				end
			end
			merge = merge & mask;
		end
	endfunction

	// ==================================================
	// register storage
	reg  [1:0]    chan_sel_reg;
	reg  [15:0]   global_function_control_reg;
	reg  [23:0]   channel_function_control_reg [0:1];
	reg  [AW-1:0] ftw_reg [0:1];
	reg  [AW-1:0] delta_reg [0:1];
	reg  [RW-1:0] rate_reg [0:1];
	reg           sw_update_reg;

	// ==================================================
	// write channel state
	reg           aw_hold_reg;
	reg           w_hold_reg;
	reg  [31:0]   awaddr_reg;
	reg  [31:0]   wdata_reg;
	reg  [3:0]    wstrb_reg;
	wire          do_write;
	wire [2:0]    wdec;
	reg  [1:0]    rd_sel;

	assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wdec     = dec_addr(awaddr_reg);

	// ==================================================
	// merged write words, cut to each register's width where stored
	wire [31:0]   sel_wr;
	wire [31:0]   glob_wr;
	wire [31:0]   chan_wr0;
	wire [31:0]   chan_wr1;
	wire [31:0]   rate_wr0;
	wire [31:0]   rate_wr1;

	assign sel_wr   = merge({30'h00000000, chan_sel_reg}, wdata_reg, wstrb_reg, 32'h00000003);
	assign glob_wr  = merge({16'h0000, global_function_control_reg},
		wdata_reg, wstrb_reg, {16'h0000, `DFC_G_MASK});
	assign chan_wr0 = merge({8'h00, channel_function_control_reg[0]},
		wdata_reg, wstrb_reg, {8'h00, `DFC_C_MASK});
	assign chan_wr1 = merge({8'h00, channel_function_control_reg[1]},
		wdata_reg, wstrb_reg, {8'h00, `DFC_C_MASK});
	assign rate_wr0 = merge({24'h000000, rate_reg[0]}, wdata_reg, wstrb_reg, 32'h000000ff);
	assign rate_wr1 = merge({24'h000000, rate_reg[1]}, wdata_reg, wstrb_reg, 32'h000000ff);

	// ==================================================
	// update event: synchronised pin rise or software strobe
	wire pin_level;
	wire pin_rise;
	wire upd;

	dfc_sync3 u_upd_sync (
		.mclk      (mclk),
		.srst      (srst),
		.pin_in    (io_update_pin),
		.level_reg (pin_level),
		.rise_reg  (pin_rise)
	);

	assign upd = pin_rise | sw_update_reg;

	// ==================================================
	// axi write handshake
	always @(posedge mclk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DFC_RESP_OKAY;
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			awaddr_reg    <= 32'h00000000;
			wdata_reg     <= 32'h00000000;
			wstrb_reg     <= 4'h0;
		end else begin
			if (!aw_hold_reg && !s_axi_bvalid && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
			end
			if (!w_hold_reg && !s_axi_bvalid && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg    <= s_axi_awaddr;
				aw_hold_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
				w_hold_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wdec == `DFC_DEC_NONE) ? `DFC_RESP_SLVERR : `DFC_RESP_OKAY;
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==================================================
	// register writes
	integer c;

	always @(posedge mclk) begin
		if (srst) begin
			chan_sel_reg                <= `DFC_SEL_RESET;
			global_function_control_reg <= `DFC_G_RESET;
			sw_update_reg               <= 1'b0;
			for (c = 0; c < 2; c = c + 1) begin
				channel_function_control_reg[c] <= `DFC_C_RESET;
				ftw_reg[c]                      <= {AW{1'b0}};
				delta_reg[c]                    <= {AW{1'b0}};
				rate_reg[c]                     <= `DFC_RATE_RESET;
			end
		end else begin
			sw_update_reg <= do_write && wdec == `DFC_DEC_UPDATE && wstrb_reg[0] && wdata_reg[0];
			if (do_write && wdec == `DFC_DEC_CHAN_SEL) begin
				chan_sel_reg <= sel_wr[1:0];
			end
			if (do_write && wdec == `DFC_DEC_GLOBAL) begin
				// sync fields are kept for read-back only
				global_function_control_reg <= glob_wr[15:0];
			end
			// channel writes land in every selected channel
			for (c = 0; c < 2; c = c + 1) begin
				if (do_write && chan_sel_reg[c]) begin
					if (wdec == `DFC_DEC_CHANNEL) begin
						channel_function_control_reg[c] <= (c == 0) ? chan_wr0[23:0] : chan_wr1[23:0];
					end
					if (wdec == `DFC_DEC_FTW) begin
						ftw_reg[c] <= merge(ftw_reg[c], wdata_reg, wstrb_reg, 32'hffffffff);
					end
					if (wdec == `DFC_DEC_DELTA) begin
						delta_reg[c] <= merge(delta_reg[c], wdata_reg, wstrb_reg, 32'hffffffff);
					end
					if (wdec == `DFC_DEC_SWEEP_RATE) begin
						rate_reg[c] <= (c == 0) ? rate_wr0[RW-1:0] : rate_wr1[RW-1:0];
					end
				end
			end
		end
	end

	// ==================================================
	// channel cores
	wire [AW-1:0] phase_w [0:1];
	wire [AW-1:0] sweep_w [0:1];
	wire [1:0]    at_end;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gen_chan
			dfc_chan_core #(
				.AW (AW),
				.RW (RW)
			) u_core (
				.mclk       (mclk),
				.srst       (srst),
				.ftw        (ftw_reg[g]),
				.delta      (delta_reg[g]),
				.rate       (rate_reg[g]),
				.sweep_en   (channel_function_control_reg[g][`DFC_C_SWEEP_EN]),
				.no_dwell   (channel_function_control_reg[g][`DFC_C_NO_DWELL]),
				.srr_upd    (channel_function_control_reg[g][`DFC_C_SRR_UPD]),
				.dig_pd     (channel_function_control_reg[g][`DFC_C_DIG_PD]),
				.upd        (upd),
				.auto_sweep (global_function_control_reg[`DFC_G_AUTO_SWEEP]),
				.clr_sweep  (global_function_control_reg[`DFC_G_CLR_SWEEP]),
				.auto_phase (global_function_control_reg[`DFC_G_AUTO_PHASE]),
				.clr_phase  (global_function_control_reg[`DFC_G_CLR_PHASE]),
				.phase_reg  (phase_w[g]),
				.sweep_reg  (sweep_w[g]),
				.at_end_reg (at_end[g])
			);
		end
	endgenerate

	assign phase_acc0 = phase_w[0];
	assign phase_acc1 = phase_w[1];
	assign sweep_acc0 = sweep_w[0];
	assign sweep_acc1 = sweep_w[1];

	// ==================================================
	// configuration outputs, all straight from register bits
	assign modulation_type_select = {channel_function_control_reg[1][`DFC_C_MOD_HI:`DFC_C_MOD_LO],
		channel_function_control_reg[0][`DFC_C_MOD_HI:`DFC_C_MOD_LO]};
	assign dac_fsc = {channel_function_control_reg[1][`DFC_C_FSC_HI:`DFC_C_FSC_LO],
		channel_function_control_reg[0][`DFC_C_FSC_HI:`DFC_C_FSC_LO]};
	assign dig_powerdown = {channel_function_control_reg[1][`DFC_C_DIG_PD],
		channel_function_control_reg[0][`DFC_C_DIG_PD]};
	// high disables the DAC, low keeps it running
	assign dac_powerdown = {channel_function_control_reg[1][`DFC_C_DAC_PD],
		channel_function_control_reg[0][`DFC_C_DAC_PD]};

	// ==================================================
	// read path
	reg  [31:0] rd_mux;
	wire [2:0]  rdec;

	assign rdec = dec_addr(s_axi_araddr);

	// reads of channel registers come from channel 0 when it is selected, else from channel 1
	always @* begin
		rd_sel = chan_sel_reg[0] ? 2'h0 : 2'h1;
		rd_mux = 32'h00000000;
		if (rdec == `DFC_DEC_CHAN_SEL) begin
			rd_mux = {30'h00000000, chan_sel_reg};
		end else if (rdec == `DFC_DEC_GLOBAL) begin
			rd_mux = {16'h0000, global_function_control_reg};
		end else if (rdec == `DFC_DEC_CHANNEL) begin
			rd_mux = {8'h00, channel_function_control_reg[rd_sel[0]]};
		end else if (rdec == `DFC_DEC_FTW) begin
			rd_mux = ftw_reg[rd_sel[0]];
		end else if (rdec == `DFC_DEC_SWEEP_RATE) begin
			rd_mux = {24'h000000, rate_reg[rd_sel[0]]};
		end else if (rdec == `DFC_DEC_DELTA) begin
			rd_mux = delta_reg[rd_sel[0]];
		end else if (rdec == `DFC_DEC_UPDATE) begin
			rd_mux = {29'h00000000, pin_level, at_end};
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `DFC_RESP_OKAY;
		end else begin
			if (!s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_mux;
				s_axi_rresp   <= (rdec == `DFC_DEC_NONE) ? `DFC_RESP_SLVERR : `DFC_RESP_OKAY;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ===== verification/dfc_chk.sv
`timescale 1ns/10ps
`include "dfc_consts.vh"

// ==================================================
// port checker: bus answers, clears, power-down
module dfc_chk #(
	parameter AW = 32,
	parameter RW = 8
) (
	input wire          mclk,
	input wire          srst,
	input wire          io_update_pin,
	input wire [31:0]   s_axi_awaddr,
	input wire          s_axi_awvalid,
	input wire          s_axi_awready,
	input wire [31:0]   s_axi_wdata,
	input wire          s_axi_wvalid,
	input wire          s_axi_wready,
	input wire [1:0]    s_axi_bresp,
	input wire          s_axi_bvalid,
	input wire          s_axi_bready,
	input wire          s_axi_arvalid,
	input wire          s_axi_arready,
	input wire          s_axi_rvalid,
	input wire [AW-1:0] phase_acc0,
	input wire [AW-1:0] phase_acc1,
	input wire [AW-1:0] sweep_acc0,
	input wire [AW-1:0] sweep_acc1,
	input wire [3:0]    dac_fsc,
	input wire [1:0]    dig_powerdown,
	input wire [1:0]    dac_powerdown
);
	reg  [15:0] glob_reg;
	wire        wr_take;

	assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

	// shadow of the global clears; assumes whole-word writes
	always @(posedge mclk)
		if (srst)
			glob_reg <= 16'h0000;
		else if (wr_take && s_axi_awaddr == {24'h0, `DFC_IDX_GLOBAL, 2'h0})
			glob_reg <= s_axi_wdata[15:0];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_wr_take;
		wr_take;
	endsequence
	sequence s_upd_rise;
		$rose(io_update_pin);
	endsequence

	a_reset_vals: assert property ($fell(srst) |-> dac_fsc == 4'hf && dac_powerdown == 2'h0)
		else $error("reset values wrong");
	a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_phase_clr: assert property (glob_reg[12] [*3] |-> phase_acc0 == 0 && phase_acc1 == 0)
		else $error("phase not held clear");
	a_sweep_clr: assert property (glob_reg[14] [*3] |-> sweep_acc0 == 0 && sweep_acc1 == 0)
		else $error("sweep not held clear");
	a_auto_phase: assert property (s_upd_rise ##0 glob_reg[13] |-> ##[3:8] (phase_acc0 == 0 && phase_acc1 == 0))
		else $error("phase autoclear missing");
	a_auto_sweep: assert property (s_upd_rise ##0 glob_reg[15] |-> ##[3:8] (sweep_acc0 == 0 && sweep_acc1 == 0))
		else $error("sweep autoclear missing");
	a_dig_freeze: assert property ((dig_powerdown[0] && glob_reg[13:12] == 2'h0) [*2] |=> $stable(phase_acc0))
		else $error("phase moved in power-down");
endmodule

bind dfc_top dfc_chk #(.AW(AW), .RW(RW)) u_chk (.mclk(mclk), .srst(srst), .io_update_pin(io_update_pin),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.phase_acc0(phase_acc0), .phase_acc1(phase_acc1), .sweep_acc0(sweep_acc0), .sweep_acc1(sweep_acc1),
	.dac_fsc(dac_fsc), .dig_powerdown(dig_powerdown), .dac_powerdown(dac_powerdown));

// ===== verification/tb.sv
`timescale 1ns/10ps
`include "dfc_consts.vh"

// ==================================================
// self-checking bench
module tb;
	localparam [31:0] A_SEL  = {24'h0, `DFC_IDX_CHAN_SEL, 2'h0};
	localparam [31:0] A_G    = {24'h0, `DFC_IDX_GLOBAL, 2'h0};
	localparam [31:0] A_C    = {24'h0, `DFC_IDX_CHANNEL, 2'h0};
	localparam [31:0] A_FTW  = {24'h0, `DFC_IDX_FTW, 2'h0};
	localparam [31:0] A_RATE = {24'h0, `DFC_IDX_SWEEP_RATE, 2'h0};
	localparam [31:0] A_DLT  = {24'h0, `DFC_IDX_DELTA, 2'h0};
	localparam [31:0] A_UPD  = {24'h0, `DFC_IDX_UPDATE, 2'h0};
	logic        mclk, srst, io_update_pin, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata, q, v, p;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] ph0, ph1, sw0, sw1;
	logic [3:0]  mods, fsc;
	logic [1:0]  dpd, apd;
	bit          pz, sz;
	int          error_cnt, total_checks;

	dfc_top #(.AW(32), .RW(8)) dut (.mclk(mclk), .srst(srst), .io_update_pin(io_update_pin),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .phase_acc0(ph0), .phase_acc1(ph1), .sweep_acc0(sw0), .sweep_acc1(sw1),
		.modulation_type_select(mods), .dac_fsc(fsc), .dig_powerdown(dpd), .dac_powerdown(apd));

	always #50 mclk = ~mclk;

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// ==================================================
	// one bus transfer; each channel released when taken
	task automatic axi(input bit we, input logic [31:0] a, input logic [31:0] d);
		bit done;
		int n;
		done = 0;
		n = 0;
		if (we) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		while (!done && n < 64) begin
			@(posedge mclk);
			n++;
			if (we && awready) awvalid <= 1'b0;
			if (we && wready) wvalid <= 1'b0;
			if (!we && arready) arvalid <= 1'b0;
			if (we && bvalid) begin
				done = 1;
				bready <= 1'b0;
				r = bresp;
			end
			if (!we && rvalid) begin
				done = 1;
				rready <= 1'b0;
				r = rresp;
				q = rdata;
			end
		end
		if (!done) chk(32'h0, 32'h1);
		@(posedge mclk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		axi(1'b1, a, d);
		chk(32'(r), 32'(`DFC_RESP_OKAY));
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		axi(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// pulse the update pin, note whether either accumulator hits zero
	task automatic scan;
		pz = 0;
		sz = 0;
		io_update_pin <= 1'b1;
		repeat (12) begin
			@(posedge mclk);
			if (ph0 === 32'h0) pz = 1;
			if (sw0 === 32'h0) sz = 1;
		end
		io_update_pin <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end

	initial begin
		{mclk, io_update_pin, awvalid, wvalid, bready, arvalid, rready} = 0;
		{awaddr, wdata, araddr} = 0;
		srst = 1'b1;
		error_cnt = 0;
		total_checks = 0;
		void'($urandom(79));
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(32'(fsc), 32'hf);
		chk(32'(apd), 32'h0);
		rd(A_C, 32'(`DFC_C_RESET));
		rd(A_G, 32'(`DFC_G_RESET));
		$display("test reset done");
		repeat (8) begin
			v = $urandom;
			wr(A_C, v);
			rd(A_C, v & 32'(`DFC_C_MASK));
			chk(32'(fsc), 32'({2{v[9:8]}}));
			chk(32'(dpd), 32'({2{v[7]}}));
			chk(32'(apd), 32'({2{v[6]}}));
			v = $urandom;
			wr(A_G, v);
			rd(A_G, v & 32'(`DFC_G_MASK));
		end
		for (int m = 0; m < 4; m++) begin
			wr(A_SEL, 32'h1);
			wr(A_C, 32'(m) << 22);
			wr(A_SEL, 32'h2);
			wr(A_C, 32'(3 - m) << 22);
			chk(32'(mods), 32'({2'(3 - m), 2'(m)}));
		end
		axi(1'b1, 32'h104, 32'hffffffff);
		chk(32'(r), 32'(`DFC_RESP_SLVERR));
		axi(1'b0, 32'h9, 32'h0);
		chk(32'(r), 32'(`DFC_RESP_SLVERR));
		chk(q, 32'h0);
		$display("test registers done");
		wr(A_SEL, 32'h3);
		wr(A_G, 32'h0);
		wr(A_FTW, 32'h100);
		wr(A_DLT, 32'h10);
		wr(A_C, 32'h4300);
		wr(A_G, 32'h5000);
		repeat (3) @(posedge mclk);
		chk(ph0 | ph1, 32'h0);
		chk(sw0 | sw1, 32'h0);
		wr(A_G, 32'h0);
		repeat (3) @(posedge mclk);
		chk(32'(|ph0), 32'h1);
		chk(32'(|sw0), 32'h1);
		scan();
		chk(32'({pz, sz}), 32'h0);
		wr(A_G, 32'ha000);
		scan();
		chk(32'({pz, sz}), 32'h3);
		wr(A_G, 32'h0);
		$display("test clears done");
		wr(A_RATE, 32'h8);
		for (int i = 0; i < 2; i++) begin
			wr(A_C, i ? 32'h4300 : 32'h6300);
			wr(A_UPD, 32'h1);
			p = sw0;
			repeat (6) wr(A_UPD, 32'h1);
			chk(32'(sw0 == p), 32'(i == 0));
		end
		wr(A_C, 32'h4380);
		p = ph0;
		repeat (5) @(posedge mclk);
		chk(ph0, p);
		// big delta overflows the sweep within two ticks of the ramp timer
		wr(A_DLT, 32'hc0000000);
		for (int i = 0; i < 2; i++) begin
			wr(A_C, i ? 32'hc300 : 32'h4300);
			wr(A_G, 32'h4000);
			wr(A_G, 32'h0);
			repeat (40) @(posedge mclk);
			chk(32'(sw0 == 32'hffffffff), 32'(i == 0));
			rd(A_UPD, i ? 32'h0 : 32'h3);
		end
		$display("test sweep done");
		stop_test();
	end
endmodule
